/* logic/tfos_pkg.sv */
package tfos_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 4;
  localparam int F1_SRC_W = 3;
  localparam int F2_SRC_W = 4;
  localparam int CMP_W = 6;
  localparam int NUM_UNIT = 2;

  // channel 0/1: shutdown_ctl_a unit 0/1, channel 2/3: shutdown_ctl_b
  localparam logic [ADDR_W-1:0] ADDR_CTL [NUM_CH] = '{
    20'hf_0670, 20'hf_0672, 20'hf_06b0, 20'hf_06b2};
  localparam logic [ADDR_W-1:0] ADDR_RELEASE = 20'hf_06c0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 20'hf_06c2;

  localparam logic [DATA_W-1:0] CTL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CTL_WRITE_MASK = 16'hf17f;

  localparam int F2_SEL_LSB = 12;
  localparam int F2_MODE_BIT = 8;
  localparam int F1_SEL_LSB = 4;
  localparam int CLR_COND_LSB = 2;
  localparam int OUT_MODE_LSB = 0;

  // status register field positions
  localparam int STAT_F1_LSB = 0;
  localparam int STAT_F2_LSB = 4;
  localparam int STAT_PEND_LSB = 8;

  typedef enum logic [1:0] {
    F1_IDLE,
    F1_ENGAGED,
    F1_RELEASE_WAIT
  } tfos_f1_state_t;

  typedef enum logic [1:0] {
    F2_IDLE,
    F2_ENGAGED,
    F2_EDGE_SEEN
  } tfos_f2_state_t;
endpackage

/* logic/tfos_sel_if.sv */
`timescale 1ns/1ps
interface tfos_sel_if;
  logic [tfos_pkg::F1_SRC_W-1:0] f1_sel;
  logic [tfos_pkg::F2_SRC_W-1:0] f2_sel;
  logic [tfos_pkg::F1_SRC_W-1:0] f1_src;
  logic [tfos_pkg::F2_SRC_W-1:0] f2_src;
  logic f1_trig;
  logic f2_trig;

  modport ctl (
    output f1_sel,
    output f2_sel,
    output f1_src,
    output f2_src,
    input f1_trig,
    input f2_trig
  );

  modport comb (
    input f1_sel,
    input f2_sel,
    input f1_src,
    input f2_src,
    output f1_trig,
    output f2_trig
  );
endinterface

/* logic/tfos_top.sv */
// What this block does
// - Ctl a bits 5 and 4 enable comparators 2 and 0 for function 1.
// - Each function engages as soon as an enabled trigger goes active.
// - Clear bit 0 low: a release write of 1 clears function 1 at any level.
// - Clear bit 0 high: a release while the trigger is active is ignored.
// - Clear bit 0 high: a release with the trigger inactive is accepted.
// - Clear bit 1 low clears at once, high at the next counter period.
// - Mode 0x gives Hi-Z, 10 low, 11 high for f1; f2 drives mode bit 0.
// - If the timer stops first, the function stays on until it restarts.
// - Ctl b bits 15 to 12 select ext irq, comparators 5, 3, 0 for f2.
// - Bit 8 low clears f2 at the next period, high at the first period after the reverse edge.
// - Ctl b bits 6 to 4 select comparators 5, 4, 0 for f1, fields below.
// - Ctl a bits 15 to 12 select ext irq, comparators 3, 2, 0 for f2.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module tfos_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [tfos_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tfos_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tfos_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [tfos_pkg::CMP_W-1:0] cmp_level,
  input wire logic external_irq_input,
  input wire logic [tfos_pkg::NUM_UNIT-1:0] timer_run_bit,
  input wire logic [tfos_pkg::NUM_UNIT-1:0] period_start,
  output logic [tfos_pkg::NUM_CH-1:0] force_active,
  output logic [tfos_pkg::NUM_CH-1:0] force_oe,
  output logic [tfos_pkg::NUM_CH-1:0] force_level
);
  logic [tfos_pkg::DATA_W-1:0] ctl [tfos_pkg::NUM_CH];
  logic [tfos_pkg::NUM_CH-1:0] release_req;
  logic [tfos_pkg::NUM_CH-1:0] f1_on;
  logic [tfos_pkg::NUM_CH-1:0] f2_on;
  logic [tfos_pkg::NUM_CH-1:0] f1_pend;
  logic [tfos_pkg::NUM_UNIT-1:0] run_prev;
  logic [tfos_pkg::NUM_UNIT-1:0] run_restart;
  logic [tfos_pkg::DATA_W-1:0] next_rdata;

  // control registers, reserved bits never stored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < tfos_pkg::NUM_CH; i++) begin
        ctl[i] <= tfos_pkg::CTL_RESET;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < tfos_pkg::NUM_CH; i++) begin
        if (reg_addr == tfos_pkg::ADDR_CTL[i]) begin
          ctl[i] <= reg_wdata & tfos_pkg::CTL_WRITE_MASK;
        end
      end
    end
  end

  // release trigger bits are write-only pulses, one per channel
  assign release_req = (reg_wr && reg_addr == tfos_pkg::ADDR_RELEASE) ?
    reg_wdata[tfos_pkg::NUM_CH-1:0] : '0;

  // read mux
  always_comb begin
    next_rdata = '0;
    for (int i = 0; i < tfos_pkg::NUM_CH; i++) begin
      if (reg_addr == tfos_pkg::ADDR_CTL[i]) begin
        next_rdata = ctl[i];
      end
    end
    if (reg_addr == tfos_pkg::ADDR_STATUS) begin
      next_rdata[tfos_pkg::STAT_F1_LSB +: tfos_pkg::NUM_CH] = f1_on;
      next_rdata[tfos_pkg::STAT_F2_LSB +: tfos_pkg::NUM_CH] = f2_on;
      next_rdata[tfos_pkg::STAT_PEND_LSB +: tfos_pkg::NUM_CH] = f1_pend;
    end
  end

  // read data stand for one cycle only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

  // timer restart detection per unit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_prev <= '0;
    end else begin
      run_prev <= timer_run_bit;
    end
  end

  assign run_restart = timer_run_bit & ~run_prev;

  for (genvar c = 0; c < tfos_pkg::NUM_CH; c++) begin : g_ch
    localparam int UNIT = c % tfos_pkg::NUM_UNIT;
    tfos_sel_if sel ();
    tfos_pkg::tfos_f1_state_t f1_state;
    tfos_pkg::tfos_f1_state_t next_f1_state;
    tfos_pkg::tfos_f2_state_t f2_state;
    tfos_pkg::tfos_f2_state_t next_f2_state;
    logic f1_prev;
    logic f2_prev;
    logic f1_rise;
    logic f2_rise;
    logic f2_fall;
    logic rel_ok;
    logic period_clear;
    logic [1:0] clr_cond;
    logic [1:0] out_mode;

    assign clr_cond = ctl[c][tfos_pkg::CLR_COND_LSB +: 2];
    assign out_mode = ctl[c][tfos_pkg::OUT_MODE_LSB +: 2];
    assign sel.f1_sel = ctl[c][tfos_pkg::F1_SEL_LSB +: tfos_pkg::F1_SRC_W];
    assign sel.f2_sel = ctl[c][tfos_pkg::F2_SEL_LSB +: tfos_pkg::F2_SRC_W];

    if (c < tfos_pkg::NUM_UNIT) begin : g_a
      assign sel.f1_src = {cmp_level[3], cmp_level[2], cmp_level[0]};
      assign sel.f2_src = {external_irq_input, cmp_level[3],
        cmp_level[2], cmp_level[0]};
    end else begin : g_b
      assign sel.f1_src = {cmp_level[5], cmp_level[4], cmp_level[0]};
      assign sel.f2_src = {external_irq_input, cmp_level[5],
        cmp_level[3], cmp_level[0]};
    end

    tfos_trig_sel u_trig_sel (
      .sel(sel.comb)
    );

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        f1_prev <= 1'b0;
        f2_prev <= 1'b0;
      end else begin
        f1_prev <= sel.f1_trig;
        f2_prev <= sel.f2_trig;
      end
    end

    assign f1_rise = sel.f1_trig & ~f1_prev;
    assign f2_rise = sel.f2_trig & ~f2_prev;
    assign f2_fall = ~sel.f2_trig & f2_prev;

    // release accepted: level-blind unless cond bit 0 set
    assign rel_ok = release_req[c] &
      (~clr_cond[0] | ~sel.f1_trig);

    // a stopped timer holds the clear until it restarts
    assign period_clear = (period_start[UNIT] & timer_run_bit[UNIT]) |
      run_restart[UNIT];

    // function 1: a new trigger edge always wins over a release
    always_comb begin
      next_f1_state = f1_state;
      case (f1_state)
        tfos_pkg::F1_IDLE: begin
          if (f1_rise) begin
            next_f1_state = tfos_pkg::F1_ENGAGED;
          end
        end
        tfos_pkg::F1_ENGAGED: begin
          if (f1_rise) begin
            next_f1_state = tfos_pkg::F1_ENGAGED;
          end else if (rel_ok && !clr_cond[1]) begin
            next_f1_state = tfos_pkg::F1_IDLE;
          end else if (rel_ok) begin
            next_f1_state = tfos_pkg::F1_RELEASE_WAIT;
          end
        end
        tfos_pkg::F1_RELEASE_WAIT: begin
          if (f1_rise) begin
            next_f1_state = tfos_pkg::F1_ENGAGED;
          end else if (period_clear) begin
            next_f1_state = tfos_pkg::F1_IDLE;
          end
        end
        default: begin
          next_f1_state = tfos_pkg::F1_IDLE;
        end
      endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        f1_state <= tfos_pkg::F1_IDLE;
      end else begin
        f1_state <= next_f1_state;
      end
    end

    // function 2: clear at the period, or at the first period after the reverse edge
    always_comb begin
      next_f2_state = f2_state;
      case (f2_state)
        tfos_pkg::F2_IDLE: begin
          if (f2_rise) begin
            next_f2_state = tfos_pkg::F2_ENGAGED;
          end
        end
        tfos_pkg::F2_ENGAGED: begin
          if (f2_rise) begin
            next_f2_state = tfos_pkg::F2_ENGAGED;
          end else if (!ctl[c][tfos_pkg::F2_MODE_BIT] && period_clear) begin
            next_f2_state = tfos_pkg::F2_IDLE;
          end else if (ctl[c][tfos_pkg::F2_MODE_BIT] && f2_fall) begin
            next_f2_state = tfos_pkg::F2_EDGE_SEEN;
          end
        end
        tfos_pkg::F2_EDGE_SEEN: begin
          if (f2_rise) begin
            next_f2_state = tfos_pkg::F2_ENGAGED;
          end else if (period_clear) begin
            next_f2_state = tfos_pkg::F2_IDLE;
          end
        end
        default: begin
          next_f2_state = tfos_pkg::F2_IDLE;
        end
      endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        f2_state <= tfos_pkg::F2_IDLE;
      end else begin
        f2_state <= next_f2_state;
      end
    end

    assign f1_on[c] = f1_state != tfos_pkg::F1_IDLE;
    assign f2_on[c] = f2_state != tfos_pkg::F2_IDLE;
    assign f1_pend[c] = f1_state == tfos_pkg::F1_RELEASE_WAIT;

    // forced pin drive; function 1 takes precedence when both are on
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        force_active[c] <= 1'b0;
        force_oe[c] <= 1'b0;
        force_level[c] <= 1'b0;
      end else if (next_f1_state != tfos_pkg::F1_IDLE) begin
        force_active[c] <= 1'b1;
        force_oe[c] <= out_mode[1];
        force_level[c] <= out_mode[1] & out_mode[0];
      end else if (next_f2_state != tfos_pkg::F2_IDLE) begin
        force_active[c] <= 1'b1;
        force_oe[c] <= 1'b1;
        force_level[c] <= out_mode[0];
      end else begin
        force_active[c] <= 1'b0;
        force_oe[c] <= 1'b0;
        force_level[c] <= 1'b0;
      end
    end
  end
endmodule // tfos_top

/* logic/tfos_trig_sel.sv */
`timescale 1ns/1ps
module tfos_trig_sel (
  tfos_sel_if.comb sel
);
  logic [tfos_pkg::F1_SRC_W-1:0] f1_masked;
  logic [tfos_pkg::F2_SRC_W-1:0] f2_masked;

  // a source counts only while its select bit is 1
  for (genvar i = 0; i < tfos_pkg::F2_SRC_W; i++) begin : g_src
    if (i < tfos_pkg::F1_SRC_W) begin : g_f1
      assign f1_masked[i] = sel.f1_sel[i] & sel.f1_src[i];
    end
    assign f2_masked[i] = sel.f2_sel[i] & sel.f2_src[i];
  end

  // any single enabled source is enough
  assign sel.f1_trig = |f1_masked;
  assign sel.f2_trig = |f2_masked;
endmodule // tfos_trig_sel

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic core_clk, rst, reg_wr, reg_rd, w_ext, ext;
  logic [tfos_pkg::ADDR_W-1:0] reg_addr;
  logic [tfos_pkg::DATA_W-1:0] reg_wdata, rdata;
  logic [tfos_pkg::CMP_W-1:0] w_cmp, cmp;
  logic [1:0] w_run, w_per, run, per;
  logic [3:0] fa, oe, lv;
  int err_count, samples_checked;
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  tfos_top i_tfos_top (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .cmp_level(cmp), .external_irq_input(ext),
    .timer_run_bit(run), .period_start(per), .force_active(fa),
    .force_oe(oe), .force_level(lv));
  tfos_far_model i_tfos_far_model (.core_clk(core_clk), .rst(rst),
    .want_cmp(w_cmp), .want_ext(w_ext), .want_run(w_run),
    .want_period(w_per), .cmp_level(cmp), .external_irq_input(ext),
    .timer_run_bit(run), .period_start(per));
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [19:0] a, logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [19:0] a, logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", rdata, exp);
  endtask
  task automatic ochk(int c, logic [2:0] e);
    repeat (4) @(posedge core_clk);
    #1 chk("force", {13'h0, fa[c], oe[c], lv[c]}, {13'h0, e});
  endtask
  // control changes only while the timer is stopped
  task automatic cfg(int c, logic [15:0] v);
    w_run <= 2'b00;
    wr(tfos_pkg::ADDR_CTL[c], v);
    w_run <= 2'b11;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic trig(logic [5:0] v, logic e);
    @(posedge core_clk);
    w_cmp <= v;
    w_ext <= e;
  endtask
  task automatic pulse(int u);
    @(posedge core_clk);
    w_per <= 2'b01 << u;
    @(posedge core_clk);
    w_per <= 2'b00;
  endtask
  task automatic rel(int c);
    wr(tfos_pkg::ADDR_RELEASE, 16'h0001 << c);
  endtask
  task automatic summarize;
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    {rst, reg_wr, reg_rd, w_ext} = 4'b1000;
    {reg_addr, reg_wdata, w_cmp, w_run, w_per} = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(tfos_pkg::ADDR_CTL[i], 16'h0000);
    rd(tfos_pkg::ADDR_STATUS, 16'h0000);
    wr(tfos_pkg::ADDR_CTL[2], 16'hffff);
    rd(tfos_pkg::ADDR_CTL[2], 16'hf17f);
    wr(20'hf_06c4, 16'hffff);
    rd(20'hf_06c4, 16'h0000);
    rd(tfos_pkg::ADDR_RELEASE, 16'h0000);
    cfg(2, 16'h0000);
    cfg(0, 16'h0011);
    trig(6'h01, 1'b0);
    ochk(0, 3'b100);
    rd(tfos_pkg::ADDR_STATUS, 16'h0001);
    rel(0);
    ochk(0, 3'b000);
    trig(6'h00, 1'b0);
    cfg(0, 16'h0016);
    trig(6'h01, 1'b0);
    ochk(0, 3'b110);
    rel(0);
    ochk(0, 3'b110);
    trig(6'h00, 1'b0);
    rel(0);
    ochk(0, 3'b000);
    cfg(0, 16'h001b);
    trig(6'h01, 1'b0);
    ochk(0, 3'b111);
    rel(0);
    ochk(0, 3'b111);
    rd(tfos_pkg::ADDR_STATUS, 16'h0101);
    pulse(0);
    ochk(0, 3'b000);
    trig(6'h00, 1'b0);
    trig(6'h01, 1'b0);
    ochk(0, 3'b111);
    rel(0);
    w_run <= 2'b10;
    pulse(0);
    ochk(0, 3'b111);
    w_run <= 2'b11;
    ochk(0, 3'b000);
    trig(6'h00, 1'b0);
    cfg(0, 16'h001f);
    trig(6'h01, 1'b0);
    ochk(0, 3'b111);
    rel(0);
    ochk(0, 3'b111);
    trig(6'h00, 1'b0);
    rel(0);
    ochk(0, 3'b111);
    pulse(0);
    ochk(0, 3'b000);
    cfg(0, 16'h0021);
    trig(6'h01, 1'b0);
    ochk(0, 3'b000);
    trig(6'h05, 1'b0);
    ochk(0, 3'b100);
    rel(0);
    trig(6'h00, 1'b0);
    cfg(3, 16'h8001);
    trig(6'h00, 1'b1);
    ochk(3, 3'b111);
    rd(tfos_pkg::ADDR_STATUS, 16'h0080);
    pulse(1);
    ochk(3, 3'b000);
    trig(6'h00, 1'b0);
    cfg(3, 16'h8101);
    trig(6'h00, 1'b1);
    pulse(1);
    ochk(3, 3'b111);
    trig(6'h00, 1'b0);
    pulse(1);
    ochk(3, 3'b000);
    cfg(3, 16'h0000);
    cfg(2, 16'h0043);
    trig(6'h20, 1'b0);
    ochk(2, 3'b111);
    rel(2);
    ochk(2, 3'b000);
    trig(6'h00, 1'b0);
    cfg(1, 16'h4000);
    trig(6'h08, 1'b0);
    ochk(1, 3'b110);
    pulse(1);
    ochk(1, 3'b000);
    summarize();
  end
endmodule // testbench

/* test/tfos_asserts.sv */
`timescale 1ns/1ps
module tfos_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [tfos_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tfos_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tfos_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [tfos_pkg::CMP_W-1:0] cmp_level,
  input wire logic external_irq_input,
  input wire logic [tfos_pkg::NUM_UNIT-1:0] timer_run_bit,
  input wire logic [tfos_pkg::NUM_UNIT-1:0] period_start,
  input wire logic [tfos_pkg::NUM_CH-1:0] force_active,
  input wire logic [tfos_pkg::NUM_CH-1:0] force_oe,
  input wire logic [tfos_pkg::NUM_CH-1:0] force_level
);
  logic [15:0] c0;
  logic rel;
  // shadow of channel 0 control
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c0 <= 16'h0000;
    end else if (reg_wr && reg_addr == tfos_pkg::ADDR_CTL[0]) begin
      c0 <= reg_wdata & tfos_pkg::CTL_WRITE_MASK;
    end
  end
  assign rel = reg_wr && reg_addr == tfos_pkg::ADDR_RELEASE &&
    reg_wdata[0] && c0[15:12] == 4'h0;
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_oe_when_on: assert property ((force_oe & ~force_active) == 4'h0)
    else $error("pin driven while not forced");
  a_mode_out: assert property (force_active[0] && c0[15:12] == 4'h0
    |-> force_oe[0] == c0[1] && (!c0[1] || force_level[0] == c0[0]))
    else $error("forced output wrong for mode");
  a_engage_rise: assert property (c0[15:12] == 4'h0 &&
    c0[6:4] == 3'b001 && $rose(cmp_level[0]) |=> force_active[0])
    else $error("no engage");
  a_unsel_quiet: assert property ($rose(force_active[0]) |->
    $past(|(c0[6:4] & {cmp_level[3], cmp_level[2], cmp_level[0]}) ||
    |(c0[15:12] & {external_irq_input, cmp_level[3:2], cmp_level[0]})))
    else $error("engaged without enabled source");
  a_release_now: assert property (rel && c0[3:2] == 2'b00 &&
    $stable(cmp_level) |=> !force_active[0]) else $error("no release");
  a_refuse_act: assert property (rel && c0[3:2] == 2'b01 &&
    c0[6:4] == 3'b001 && cmp_level[0] && force_active[0] |=> force_active[0])
    else $error("release taken while trigger active");
  a_defer_clr: assert property (rel && c0[3] && force_active[0] &&
    !period_start[0] && !$rose(timer_run_bit[0]) |=> force_active[0])
    else $error("clear not deferred");
  a_stop_hold: assert property (force_active[0] &&
    !timer_run_bit[0] && !reg_wr |=> force_active[0])
    else $error("cleared while stopped");
  c_engage: cover property ($rose(force_active[0]));
  c_release: cover property (rel ##1 !force_active[0]);
  c_f2_clear: cover property ($fell(force_active[3]));
endmodule // tfos_asserts
bind tfos_top tfos_asserts i_tfos_asserts (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_level(cmp_level),
  .external_irq_input(external_irq_input), .timer_run_bit(timer_run_bit),
  .period_start(period_start), .force_active(force_active),
  .force_oe(force_oe), .force_level(force_level));

/* test/tfos_far_model.sv */
`timescale 1ns/1ps
module tfos_far_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [tfos_pkg::CMP_W-1:0] want_cmp,
  input wire logic want_ext,
  input wire logic [tfos_pkg::NUM_UNIT-1:0] want_run,
  input wire logic [tfos_pkg::NUM_UNIT-1:0] want_period,
  output logic [tfos_pkg::CMP_W-1:0] cmp_level,
  output logic external_irq_input,
  output logic [tfos_pkg::NUM_UNIT-1:0] timer_run_bit,
  output logic [tfos_pkg::NUM_UNIT-1:0] period_start
);
  // comparators run with stop enable set, so levels always reach the block
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_level <= '0;
      external_irq_input <= 1'b0;
      timer_run_bit <= '0;
      period_start <= '0;
    end else begin
      cmp_level <= want_cmp;
      external_irq_input <= want_ext;
      timer_run_bit <= want_run;
      // a stopped timer makes no period boundary
      period_start <= want_period & want_run;
    end
  end
endmodule // tfos_far_model
